// *** uefs_top.sv ***
module uefs_top
	import uefs_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic [7:0] line_control_i,
	input  wire logic [1:0] flow_state_i,
	input  wire logic       remote_told_stop_i,
	input  wire logic       local_halted_i,
	input  wire logic       char_ready_i,
	input  wire logic       shift_busy_i,
	input  wire logic       rts_n_i,
	output logic [7:0]      reg_rdata_o,
	output logic            irda_quarter_o,
	output logic            rx_enable_o,
	output logic            nine_bit_o,
	output logic            load_shift_o,
	output logic            rts_n_o,
	output logic            intr_set_sel_o,
	output logic [7:0]      special_func_o
);
	logic [7:0] extra_feat_q;
	logic [7:0] unlock_key_q;
	logic [7:0] special_func_q;
	logic [7:0] flow_status_q;
	logic       tx_active;
	logic       line_special;
	logic       access_en;
	logic       sel_extra;
	logic       sel_key;
	logic       sel_special;
	logic       sel_status;

	function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
		return addr == ofs;
	endfunction

	assign line_special = line_control_i == LINE_CTRL_SPECIAL;
	assign access_en    = special_func_q[SF_ACCESS_EN];
	assign sel_extra    = hit(reg_addr_i, OFS_EXTRA_FEAT) & ~access_en;
	assign sel_key      = hit(reg_addr_i, OFS_UNLOCK_KEY) & line_special;
	assign sel_special  = hit(reg_addr_i, OFS_SPECIAL_FUNC) & line_special
		& (unlock_key_q == UNLOCK_KEY_VALUE);
	assign sel_status   = hit(reg_addr_i, OFS_FLOW_STATUS) & line_special & access_en;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			extra_feat_q <= EXTRA_FEAT_RESET;
		end else if (reg_wr_i && sel_extra) begin
			extra_feat_q <= reg_wdata_i & EF_WRITE_MASK;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			unlock_key_q <= UNLOCK_KEY_RESET;
		end else if (reg_wr_i && sel_key) begin
			unlock_key_q <= reg_wdata_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			special_func_q <= SPECIAL_FUNC_RESET;
		end else if (reg_wr_i && sel_special) begin
			special_func_q <= reg_wdata_i;
		end
	end

	// live flow status, sampled every cycle
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			flow_status_q <= FLOW_STATUS_RESET;
		end else begin
			flow_status_q <= {2'b00, flow_state_i, 2'b00,
				remote_told_stop_i, local_halted_i};
		end
	end

	// read data one cycle after the strobe, zero when nothing answers
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (1'b1)
				sel_extra:   reg_rdata_o <= extra_feat_q;
				sel_key:     reg_rdata_o <= unlock_key_q;
				sel_special: reg_rdata_o <= special_func_q;
				sel_status:  reg_rdata_o <= flow_status_q;
				default:     reg_rdata_o <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			irda_quarter_o <= 1'b0;
			rx_enable_o    <= 1'b1;
			nine_bit_o     <= 1'b0;
			intr_set_sel_o <= 1'b0;
			special_func_o <= SPECIAL_FUNC_RESET;
		end else begin
			irda_quarter_o <= extra_feat_q[EF_IRDA_FAST];
			rx_enable_o    <= ~extra_feat_q[EF_RX_OFF];
			nine_bit_o     <= extra_feat_q[EF_NINE_BIT];
			intr_set_sel_o <= hit(reg_addr_i, OFS_EXTRA_FEAT) & access_en
				& line_special;
			special_func_o <= special_func_q;
		end
	end

	uefs_tx_gate u_tx_gate (
		.core_clk_i   (core_clk_i),
		.rst_i        (rst_i),
		.tx_off_i     (extra_feat_q[EF_TX_OFF]),
		.char_ready_i (char_ready_i),
		.shift_busy_i (shift_busy_i),
		.load_shift_o (load_shift_o),
		.tx_active_o  (tx_active)
	);

	uefs_rs485_dir u_dir (
		.core_clk_i  (core_clk_i),
		.rst_i       (rst_i),
		.auto_dir_i  (extra_feat_q[EF_DIR_AUTO]),
		.dir_pol_i   (extra_feat_q[EF_DIR_POL]),
		.tx_active_i (tx_active),
		.rts_n_i     (rts_n_i),
		.rts_n_o     (rts_n_o)
	);
endmodule

// *** uefs_pkg.sv ***
// Overview of operation
// - bit 7 of extra_feature_control picks 1/4-bit infrared pulses when set, 3/16-bit when clear.
// - bit 5 makes the rs485 direction output high while sending when set, low while sending when clear.
// - the polarity bit only reaches the rts pin while bit 4 is set.
// - bit 4 hands the rts pin to the transmitter as a driver-direction signal; clear leaves rts alone.
// - bit 2 stops new characters on tx once the one in the transmit_shift_register has gone out.
// - bit 1 disables the receiver when set.
// - bit 0 selects 9-bit multidrop characters, clear keeps 8-bit characters.
// - extra_feature_control is reached at its offset only while the access enable bit is 0; reset 00.
// - with line_control at bf, software writes 5a to special_unlock_key to open special_function_control.
// - advanced_flow_status is read only with line_control bf and the access enable bit 1; reset 00.
// - status bits 5:4 give the software flow state: idle, xoff received, tx off, xon received.
// - status bit 1 is set while this device has told the far end to stop, by xoff or rts.
// - status bit 0 is set while the local transmitter is halted by the far end.
// - access enable bit 2 of special_function_control moves the shared offset to the interrupt set while line_control is bf.
// - special_function_control is reached only with line_control bf and the key at 5a.
package uefs_pkg;
	localparam logic [3:0] OFS_FLOW_STATUS  = 4'h2;
	localparam logic [3:0] OFS_SPECIAL_FUNC = 4'h7;
	localparam logic [3:0] OFS_UNLOCK_KEY   = 4'hd;
	localparam logic [3:0] OFS_EXTRA_FEAT   = 4'hf;

	localparam logic [7:0] LINE_CTRL_SPECIAL = 8'hbf;
	localparam logic [7:0] UNLOCK_KEY_VALUE  = 8'h5a;

	localparam int EF_IRDA_FAST  = 7;
	localparam int EF_DIR_POL    = 5;
	localparam int EF_DIR_AUTO   = 4;
	localparam int EF_TX_OFF     = 2;
	localparam int EF_RX_OFF     = 1;
	localparam int EF_NINE_BIT   = 0;
	localparam logic [7:0] EF_WRITE_MASK = 8'hb7;

	localparam int SF_ACCESS_EN  = 2;

	localparam int FS_STATE_LO   = 4;
	localparam int FS_REMOTE_OFF = 1;
	localparam int FS_LOCAL_HALT = 0;

	localparam logic [7:0] EXTRA_FEAT_RESET   = 8'h00;
	localparam logic [7:0] UNLOCK_KEY_RESET   = 8'h00;
	localparam logic [7:0] SPECIAL_FUNC_RESET = 8'h00;
	localparam logic [7:0] FLOW_STATUS_RESET  = 8'h00;

	typedef enum logic [1:0] {
		UEFS_FLOW_IDLE = 2'b00,
		UEFS_FLOW_XOFF = 2'b01,
		UEFS_FLOW_TXOFF = 2'b10,
		UEFS_FLOW_XON  = 2'b11
	} uefs_flow_e;
endpackage

// *** uefs_rs485_dir.sv ***
module uefs_rs485_dir
	import uefs_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic auto_dir_i,
	input  wire logic dir_pol_i,
	input  wire logic tx_active_i,
	input  wire logic rts_n_i,
	output logic      rts_n_o
);
	// rts idles high (deasserted) out of reset
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rts_n_o <= 1'b1;
		end else if (auto_dir_i) begin
			rts_n_o <= dir_pol_i ? tx_active_i : ~tx_active_i;
		end else begin
			rts_n_o <= rts_n_i;
		end
	end
endmodule

// *** uefs_tx_gate.sv ***
module uefs_tx_gate
	import uefs_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic tx_off_i,
	input  wire logic char_ready_i,
	input  wire logic shift_busy_i,
	output logic      load_shift_o,
	output logic      tx_active_o
);
	// a load only starts a new character; one already shifting runs to its end
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			load_shift_o <= 1'b0;
		end else begin
			load_shift_o <= char_ready_i & ~shift_busy_i & ~tx_off_i & ~load_shift_o;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			tx_active_o <= 1'b0;
		end else begin
			tx_active_o <= shift_busy_i | load_shift_o;
		end
	end
endmodule

// *** uefs_asserts.sv ***
module uefs_asserts
	import uefs_pkg::*;
(
	input wire logic       core_clk_i,
	input wire logic       rst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] line_control_i,
	input wire logic       shift_busy_i,
	input wire logic       rts_n_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       load_shift_o,
	input wire logic       rts_n_o,
	input wire logic [7:0] special_func_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	wire ef = reg_wr_i && reg_addr_i == OFS_EXTRA_FEAT && !special_func_o[SF_ACCESS_EN];
	wire lk = line_control_i != LINE_CTRL_SPECIAL;
	chk_load_one_cycle: assert property (load_shift_o |=> !load_shift_o)
		else $error("load pulse too long");
	chk_tx_off_holds: assert property (ef && reg_wdata_i[EF_TX_OFF] |=> ##2 !load_shift_o)
		else $error("load while tx off");
	chk_status_locked: assert property (reg_rd_i && reg_addr_i == OFS_FLOW_STATUS && lk |=>
		reg_rdata_o == 8'h00) else $error("status read while locked");
	chk_ef_reserved: assert property (reg_rd_i && reg_addr_i == OFS_EXTRA_FEAT |=>
		!reg_rdata_o[6] && !reg_rdata_o[3]) else $error("reserved bit set");
	chk_rts_pass: assert property (ef && !reg_wdata_i[EF_DIR_AUTO] |=> ##1
		rts_n_o == $past(rts_n_i)) else $error("rts not passed through");
	chk_rts_idle_pol: assert property (ef && reg_wdata_i[EF_DIR_AUTO] ##1
		(!shift_busy_i && !load_shift_o) [*3] |-> rts_n_o == !$past(reg_wdata_i[EF_DIR_POL], 3))
		else $error("idle direction level wrong");
	chk_reset_state: assert property (disable iff (1'b0) rst_i |=>
		rts_n_o && !load_shift_o && special_func_o == 8'h00) else $error("reset state wrong");
	chk_sf_locked: assert property (reg_wr_i && reg_addr_i == OFS_SPECIAL_FUNC && lk |=>
		##1 $stable(special_func_o)) else $error("special written while locked");
	cover property (load_shift_o);
	cover property (ef && reg_wdata_i[EF_DIR_AUTO]);
	cover property (reg_rd_i && reg_addr_i == OFS_FLOW_STATUS && !lk);
endmodule

// *** uefs_far_model.sv ***
module uefs_far_model (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic load_i,
	output logic      busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q;
	// shift register busy from the cycle after a load until the char is out
	always_ff @(posedge core_clk_i) begin
		if (rst_i) cnt_q <= 4'h0;
		else if (load_i) cnt_q <= 4'h8;
		else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
	end
	assign busy_o = !rst_i && cnt_q != 4'h0;
endmodule

// *** uefs_tb_top.sv ***
module uefs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import uefs_pkg::*;
	logic       core_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, rts_n_i = 1;
	logic       remote_told_stop_i = 0, local_halted_i = 0, char_ready_i = 0, shift_busy_i;
	logic       irda_quarter_o, rx_enable_o, nine_bit_o, load_shift_o, rts_n_o, intr_set_sel_o;
	logic [3:0] reg_addr_i = 4'h0;
	logic [1:0] flow_state_i = 2'b00;
	logic [7:0] reg_wdata_i = 8'h00, line_control_i = 8'h00, reg_rdata_o, special_func_o, rv;
	int         miscompares = 0, n_compared = 0, cyc = 0, n, m;
	logic [7:0] rows [8][4] = '{
		'{8'hff, 8'h01, 8'hb7, 8'h00}, '{8'h48, 8'h01, 8'h00, 8'h01},
		'{8'h81, 8'h00, 8'h81, 8'h00}, '{8'h02, 8'h01, 8'h02, 8'h01},
		'{8'h30, 8'h01, 8'h30, 8'h00}, '{8'h10, 8'h00, 8'h10, 8'h01},
		'{8'h20, 8'h01, 8'h20, 8'h01}, '{8'h20, 8'h00, 8'h20, 8'h00}};
	uefs_top dut (.*);
	uefs_far_model far (.core_clk_i(core_clk_i), .rst_i(rst_i), .load_i(load_shift_o),
		.busy_o(shift_busy_i));
	always #5 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) if (++cyc == 3000) begin
		miscompares++;
		conclude();
	end
	task automatic chk(string nm, logic [7:0] s, e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 rv = reg_rdata_o;
	endtask
	task automatic count();
		n = 0;
		m = 0;
		repeat (20) @(posedge core_clk_i) begin
			#1 n += load_shift_o;
			m += !rts_n_o;
		end
	endtask
	task automatic conclude();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		#1 chk("rst_rdata", reg_rdata_o, 8'h00);
		chk("rst_rx", rx_enable_o, 1'b1);
		foreach (rows[i]) begin
			rts_n_i <= rows[i][1][0];
			wr(OFS_EXTRA_FEAT, rows[i][0]);
			rd(OFS_EXTRA_FEAT);
			chk("ef", rv, rows[i][2]);
			chk("irda", irda_quarter_o, rows[i][0][7]);
			chk("rx_en", rx_enable_o, !rows[i][0][1]);
			chk("nine", nine_bit_o, rows[i][0][0]);
			chk("rts", rts_n_o, rows[i][3]);
		end
		$display("register rows done");
		wr(OFS_EXTRA_FEAT, 8'h10);
		char_ready_i <= 1'b1;
		count();
		chk("load_on", n > 0, 1'b1);
		chk("rts_tx", m > 0, 1'b1);
		wr(OFS_EXTRA_FEAT, 8'h14);
		repeat (12) @(posedge core_clk_i);
		count();
		chk("load_off", n[7:0], 8'h00);
		chk("rts_rx", m[7:0], 8'h00);
		rd(OFS_FLOW_STATUS);
		chk("st_locked", rv, 8'h00);
		$display("transmit gate done");
		@(posedge core_clk_i);
		char_ready_i <= 1'b0;
		line_control_i <= LINE_CTRL_SPECIAL;
		flow_state_i <= UEFS_FLOW_TXOFF;
		remote_told_stop_i <= 1'b1;
		wr(OFS_SPECIAL_FUNC, 8'h04);
		@(posedge core_clk_i) #1 chk("sf_locked", special_func_o, 8'h00);
		wr(OFS_UNLOCK_KEY, UNLOCK_KEY_VALUE);
		wr(OFS_SPECIAL_FUNC, 8'h04);
		rd(OFS_FLOW_STATUS);
		chk("status", rv, 8'h22);
		chk("sf_open", special_func_o, 8'h04);
		@(posedge core_clk_i);
		local_halted_i <= 1'b1;
		remote_told_stop_i <= 1'b0;
		flow_state_i <= UEFS_FLOW_XOFF;
		rd(OFS_FLOW_STATUS);
		chk("status2", rv, 8'h11);
		flow_state_i <= UEFS_FLOW_XON;
		remote_told_stop_i <= 1'b1;
		rd(OFS_FLOW_STATUS);
		chk("status3", rv, 8'h33);
		wr(OFS_EXTRA_FEAT, 8'h01);
		#1 chk("isel_on", intr_set_sel_o, 8'h01);
		wr(OFS_SPECIAL_FUNC, 8'h00);
		rd(OFS_EXTRA_FEAT);
		chk("ef_hidden", rv, 8'h14);
		chk("isel_off", intr_set_sel_o, 8'h00);
		rd(4'h3);
		chk("unmapped", rv, 8'h00);
		$display("unlock sequence done");
		wr(OFS_EXTRA_FEAT, 8'h81);
		line_control_i <= 8'h00;
		wr(OFS_SPECIAL_FUNC, 8'hff);
		@(posedge core_clk_i) #1 chk("sf_lcr", special_func_o, 8'h00);
		rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		#1 chk("rst_irda", irda_quarter_o, 8'h00);
		chk("rst_nine", nine_bit_o, 8'h00);
		line_control_i <= LINE_CTRL_SPECIAL;
		wr(OFS_SPECIAL_FUNC, 8'h04);
		@(posedge core_clk_i) #1 chk("rst_key", special_func_o, 8'h00);
		rd(OFS_EXTRA_FEAT);
		chk("rst_ef", rv, 8'h00);
		$display("mid-run reset done");
		conclude();
	end
endmodule
bind uefs_top uefs_asserts chk_i (
	.core_clk_i     (core_clk_i),
	.rst_i          (rst_i),
	.reg_addr_i     (reg_addr_i),
	.reg_wr_i       (reg_wr_i),
	.reg_rd_i       (reg_rd_i),
	.reg_wdata_i    (reg_wdata_i),
	.line_control_i (line_control_i),
	.shift_busy_i   (shift_busy_i),
	.rts_n_i        (rts_n_i),
	.reg_rdata_o    (reg_rdata_o),
	.load_shift_o   (load_shift_o),
	.rts_n_o        (rts_n_o),
	.special_func_o (special_func_o)
);
